// file: hw/sdc_pkg.sv
// Shared constants and types for the SDRAM host controller
package sdc_pkg;
    // ========================================
    // Timing
    localparam int CLK_NS      = 100;
    localparam int INIT_WAIT_NS = 100000;
    localparam int TRCD_NS     = 20;
    localparam int TRP_NS      = 20;
    localparam int TRFC_NS     = 70;
    localparam int WR_REC_NS   = 15;
    localparam int REFI_NS     = 15600;
    localparam logic [9:0] INIT_CYC = 10'((INIT_WAIT_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [9:0] TRCD_CYC = 10'((TRCD_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [9:0] TRP_CYC  = 10'((TRP_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [9:0] TRFC_CYC = 10'((TRFC_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [9:0] TWR_CYC  = 10'((WR_REC_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [9:0] TMRD_CYC = 10'h002;
    localparam logic [7:0] REFI_CYC = 8'(REFI_NS / CLK_NS);
    // ========================================
    // Commands {cs_n, ras_n, cas_n, we_n}
    localparam logic [3:0] CMD_LMR  = 4'h0;
    localparam logic [3:0] CMD_REF  = 4'h1;
    localparam logic [3:0] CMD_PRE  = 4'h2;
    localparam logic [3:0] CMD_ACT  = 4'h3;
    localparam logic [3:0] CMD_WR   = 4'h4;
    localparam logic [3:0] CMD_RD   = 4'h5;
    localparam logic [3:0] CMD_TERM = 4'h6;
    localparam logic [3:0] CMD_NOP  = 4'h7;
    // ========================================
    // Mode word fields
    localparam int BL_LSB = 0;
    localparam int ORDER_BIT = 3;
    localparam int CL_LSB = 4;
    localparam int OPM_LSB = 7;
    localparam int SWR_BIT = 9;
    localparam logic [2:0] BL_1 = 3'h0;
    localparam logic [2:0] BL_2 = 3'h1;
    localparam logic [2:0] BL_4 = 3'h2;
    localparam logic [2:0] BL_8 = 3'h3;
    localparam logic [2:0] BL_PAGE = 3'h7;
    localparam logic [2:0] CL_3 = 3'h3;
    localparam logic [12:0] MODE_RST = 13'h0020;
    localparam int AP_BIT = 10;
    // ========================================
    // Memory geometry and access word {bank, row, col}
    localparam int COL_W  = 8;
    localparam int ROW_W  = 11;
    localparam int BANK_W = 2;
    localparam int ACC_W  = COL_W + ROW_W + BANK_W;
    // ========================================
    // Register offsets and fields
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_ADDR   = 8'h04;
    localparam logic [7:0] REG_WDATA  = 8'h08;
    localparam logic [7:0] REG_RDATA  = 8'h0c;
    localparam logic [7:0] REG_MODE   = 8'h10;
    localparam logic [7:0] REG_STATUS = 8'h14;
    localparam int CTRL_GO = 0;
    localparam int CTRL_WR = 1;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ========================================
    // Types
    typedef enum logic [3:0] {
        S_PWR  = 4'h0, S_IPRE = 4'h1, S_IREF = 4'h2, S_LMR  = 4'h3,
        S_IDLE = 4'h4, S_RW   = 4'h5, S_TERM = 4'h6, S_PRE  = 4'h7,
        S_WAIT = 4'h8
    } sdc_st_e;
    typedef struct packed {
        logic        cke;
        logic [3:0]  cmd;
        logic [1:0]  ba;
        logic [10:0] addr;
        logic [3:0]  dqm;
        logic [31:0] dq_o;
        logic        dq_oe;
    } sdc_pin_s;
    typedef struct packed {
        sdc_st_e          st;
        sdc_st_e          nxt;
        logic [9:0]       cnt;
        logic [7:0]       refcnt;
        logic             refpend;
        logic [1:0]       refs;
        logic [2:0]       cap;
        logic             rd_stb;
        logic             open;
        logic             init_done;
        logic             go;
        logic             wr;
        logic             mode_pend;
        logic [12:0]      mode;
        logic [ACC_W-1:0] acc;
        logic [31:0]      wdata;
        logic [31:0]      rdata;
        sdc_pin_s         pin;
        logic             awg;
        logic             wg;
        logic [7:0]       waddr;
        logic [31:0]      wval;
        logic [3:0]       wstrb;
        logic             bvalid;
        logic [1:0]       bresp;
        logic             rvalid;
        logic [1:0]       rresp;
        logic [31:0]      rdat;
    } sdc_state_s;
endpackage

// file: hw/sdc_host.sv
// SDRAM host controller with an AXI4-Lite command port
//
// The AXI4-Lite register port and the placing of the registers were decided locally.
`timescale 1ns/1ns
// What this block does
// RQ1 - Interrupted auto precharge bank precharges itself
// RQ2 - Interrupting read owns bus CAS latency later
// RQ3 - Mask data one clock before write
// RQ4 - Read cuts write; last data precedes read
// RQ5 - Write cuts write; last data one clock earlier
// RQ6 - Interrupted read-AP bank precharges at new read
// RQ7 - Mask data two clocks before write
// RQ8 - Write-AP cut by read: recovery then precharge
// RQ9 - Write-AP cut by write: recovery then precharge
// RQ10 - Pins sampled on rising clock edge
// RQ11 - Four banks, 2048 rows, 256 words
// RQ12 - Bank/row on activate, column on access
// RQ13 - Activate row before read or write
// RQ14 - Only NOPs during 100us power-up wait
// RQ15 - Precharge all, two refreshes, then mode
// RQ16 - Load mode before any operational command
// RQ17 - Mode changes only by load-mode command
// RQ18 - Mode word field layout fixed
// RQ19 - Load mode only with all banks idle
// RQ20 - Burst 1/2/4/8 any order; page sequential
// RQ21 - Full page burst ended by terminate
// RQ22 - Bursts wrap in aligned block
// RQ23 - Read data valid CAS latency after command
// RQ24 - Single-write bit makes writes one beat
// RQ25 - Operating mode bits always zero
// RQ26 - Order bit: sequential or interleaved
// RQ27 - Burst and latency code encodings
// RQ28 - Track bank state before next command
module sdc_host (
    // Clock and reset
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // AXI4-Lite write
    input  wire logic [7:0]        awaddr,
    input  wire logic              awvalid,
    output logic                   awready,
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output logic                   wready,
    output logic [1:0]             bresp,
    output logic                   bvalid,
    input  wire logic              bready,
    // AXI4-Lite read
    input  wire logic [7:0]        araddr,
    input  wire logic              arvalid,
    output logic                   arready,
    output logic [31:0]            rdata,
    output logic [1:0]             rresp,
    output logic                   rvalid,
    input  wire logic              rready,
    // Memory pins
    output sdc_pkg::sdc_pin_s      mem,
    input  wire logic [31:0]       dq_i
);
    // ========================================
    // State
    sdc_pkg::sdc_state_s q;
    sdc_pkg::sdc_state_s d;
    logic [3:0] beats;
    logic [2:0] cl;
    logic       page;
    logic       busy;
    logic       mode_wr;
    localparam int ACC_W_M1 = sdc_pkg::ACC_W - 1;

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  be);
        logic [31:0] m;
        m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        return (old & ~m) | (nw & m);
    endfunction

    // ========================================
    // Mode decode
    always_comb begin
        unique case (q.mode[sdc_pkg::BL_LSB +: 3])               // RQ27
            sdc_pkg::BL_1: beats = 4'h1;
            sdc_pkg::BL_2: beats = 4'h2;
            sdc_pkg::BL_4: beats = 4'h4;
            sdc_pkg::BL_8: beats = 4'h8;
            default:       beats = 4'h1;
        endcase
        if (q.wr && q.mode[sdc_pkg::SWR_BIT]) begin
            beats = 4'h1;                                       // RQ24
        end
        cl   = (q.mode[sdc_pkg::CL_LSB +: 3] == sdc_pkg::CL_3) ? 3'h3
                                                               : 3'h2;
        page = q.mode[sdc_pkg::BL_LSB +: 3] == sdc_pkg::BL_PAGE; // RQ20
        busy = q.go || q.st != sdc_pkg::S_IDLE || !q.init_done;
        mode_wr = q.awg && q.wg && !q.bvalid && q.waddr == sdc_pkg::REG_MODE;
    end

    assign awready = !q.awg && !q.bvalid;
    assign wready  = !q.wg && !q.bvalid;
    assign arready = !q.rvalid;
    assign bvalid  = q.bvalid;
    assign bresp   = q.bresp;
    assign rvalid  = q.rvalid;
    assign rresp   = q.rresp;
    assign rdata   = q.rdat;
    assign mem     = q.pin;                                     // RQ10

    // ========================================
    // Next state
    always_comb begin
        d = q;
        d.pin.cmd   = sdc_pkg::CMD_NOP;
        d.pin.dq_oe = 1'b0;
        d.pin.dqm   = (q.cap != 3'h0) ? 4'h0 : 4'hf;            // RQ3 RQ7
        d.rd_stb    = 1'b0;
        if (q.cnt != 10'h000) begin
            d.cnt = q.cnt - 10'h001;
        end
        if (q.refcnt == 8'h00) begin
            d.refcnt  = sdc_pkg::REFI_CYC;
            d.refpend = q.init_done;
        end else begin
            d.refcnt = q.refcnt - 8'h01;
        end
        if (q.cap != 3'h0) begin
            d.cap = q.cap - 3'h1;
            if (q.cap == 3'h1) begin
                d.rdata  = dq_i;                                // RQ23
                d.rd_stb = 1'b1;
            end
        end
        // Register bus
        if (awvalid && awready) begin
            d.awg   = 1'b1;
            d.waddr = awaddr;
        end
        if (wvalid && wready) begin
            d.wg    = 1'b1;
            d.wval  = wdata;
            d.wstrb = wstrb;
        end
        if (q.bvalid && bready) begin
            d.bvalid = 1'b0;
        end
        if (q.awg && q.wg && !q.bvalid) begin
            d.awg    = 1'b0;
            d.wg     = 1'b0;
            d.bvalid = 1'b1;
            d.bresp  = sdc_pkg::RESP_OKAY;
            unique case (q.waddr)
                sdc_pkg::REG_CTRL: begin
                    if (q.wstrb[0] && q.wval[sdc_pkg::CTRL_GO] && !busy) begin
                        d.go = 1'b1;
                        d.wr = q.wval[sdc_pkg::CTRL_WR];
                    end
                end
                sdc_pkg::REG_ADDR: begin
                    d.acc = sdc_pkg::ACC_W'(merge(32'(q.acc), q.wval,
                                                  q.wstrb));
                end
                sdc_pkg::REG_WDATA: begin
                    d.wdata = merge(q.wdata, q.wval, q.wstrb);
                end
                sdc_pkg::REG_MODE: begin
                    d.mode      = 13'(merge(32'(q.mode), q.wval, q.wstrb));
                    d.mode_pend = 1'b1;                         // RQ17
                end
                sdc_pkg::REG_RDATA, sdc_pkg::REG_STATUS: begin
                end
                default: d.bresp = sdc_pkg::RESP_SLVERR;
            endcase
        end
        if (q.rvalid && rready) begin
            d.rvalid = 1'b0;
        end
        if (arvalid && arready) begin
            d.rvalid = 1'b1;
            d.rresp  = sdc_pkg::RESP_OKAY;
            unique case (araddr)
                sdc_pkg::REG_CTRL:   d.rdat = {30'h0, q.wr, q.go};
                sdc_pkg::REG_ADDR:   d.rdat = 32'(q.acc);
                sdc_pkg::REG_WDATA:  d.rdat = q.wdata;
                sdc_pkg::REG_RDATA:  d.rdat = q.rdata;
                sdc_pkg::REG_MODE:   d.rdat = 32'(q.mode);
                sdc_pkg::REG_STATUS: d.rdat = {24'h0, q.st, q.open,
                                               busy, q.mode_pend,
                                               q.init_done};
                default: begin
                    d.rdat  = 32'h0;
                    d.rresp = sdc_pkg::RESP_SLVERR;
                end
            endcase
        end
        // Memory sequencer
        unique case (q.st)
            sdc_pkg::S_PWR: begin
                if (q.cnt == 10'h000) begin                     // RQ14
                    d.st = sdc_pkg::S_IPRE;
                end
            end
            sdc_pkg::S_IPRE: begin
                d.pin.cmd          = sdc_pkg::CMD_PRE;          // RQ15
                d.pin.addr         = 11'h000;
                d.pin.addr[sdc_pkg::AP_BIT] = 1'b1;
                d.cnt = sdc_pkg::TRP_CYC;
                d.st  = sdc_pkg::S_WAIT;
                d.nxt = sdc_pkg::S_IREF;
            end
            sdc_pkg::S_IREF: begin
                d.pin.cmd = sdc_pkg::CMD_REF;                   // RQ15
                d.refs    = q.refs + 2'h1;
                d.cnt     = sdc_pkg::TRFC_CYC;
                d.st      = sdc_pkg::S_WAIT;
                d.nxt     = (q.refs == 2'h1) ? sdc_pkg::S_LMR
                                             : sdc_pkg::S_IREF;
            end
            sdc_pkg::S_LMR: begin
                d.pin.cmd  = sdc_pkg::CMD_LMR;                  // RQ16
                d.pin.ba   = 2'h0;
                d.pin.addr = q.mode[10:0];                      // RQ18
                d.pin.addr[sdc_pkg::OPM_LSB +: 2] = 2'h0;       // RQ25
                // A mode write in this cycle asks for another load
                d.mode_pend = mode_wr;
                d.init_done = 1'b1;
                d.cnt = sdc_pkg::TMRD_CYC;
                d.st  = sdc_pkg::S_WAIT;
                d.nxt = sdc_pkg::S_IDLE;
            end
            sdc_pkg::S_IDLE: begin
                d.open = 1'b0;
                if (q.refpend) begin
                    d.pin.cmd = sdc_pkg::CMD_REF;
                    // A new interval ending now keeps its request
                    d.refpend = q.refcnt == 8'h00;
                    d.cnt = sdc_pkg::TRFC_CYC;
                    d.st  = sdc_pkg::S_WAIT;
                    d.nxt = sdc_pkg::S_IDLE;
                end else if (q.mode_pend) begin
                    d.st = sdc_pkg::S_LMR;                      // RQ19
                end else if (q.go) begin
                    d.pin.cmd  = sdc_pkg::CMD_ACT;              // RQ13
                    d.pin.ba   = q.acc[ACC_W_M1 -: 2];          // RQ12
                    d.pin.addr = q.acc[sdc_pkg::COL_W +: 11];
                    d.open = 1'b1;
                    d.go   = 1'b0;
                    d.cnt  = sdc_pkg::TRCD_CYC;
                    d.st   = sdc_pkg::S_WAIT;
                    d.nxt  = sdc_pkg::S_RW;
                end
            end
            sdc_pkg::S_RW: begin
                d.pin.cmd  = q.wr ? sdc_pkg::CMD_WR : sdc_pkg::CMD_RD;
                d.pin.addr = {3'h0, q.acc[sdc_pkg::COL_W-1:0]}; // RQ12
                d.pin.addr[sdc_pkg::AP_BIT] = !page;            // RQ1
                d.pin.dqm  = 4'h0;
                if (q.wr) begin
                    d.pin.dq_o  = q.wdata;
                    d.pin.dq_oe = 1'b1;
                    d.cnt = 10'(beats) + sdc_pkg::TWR_CYC
                          + sdc_pkg::TRP_CYC;                   // RQ9
                end else begin
                    d.cap = cl + 3'h1;                          // RQ2
                    d.cnt = 10'(beats) + 10'(cl) + sdc_pkg::TRP_CYC;
                end
                d.st = page ? sdc_pkg::S_TERM : sdc_pkg::S_WAIT; // RQ28
                d.nxt = sdc_pkg::S_IDLE;
            end
            sdc_pkg::S_TERM: begin
                d.pin.cmd = sdc_pkg::CMD_TERM;                  // RQ21
                d.cnt = q.wr ? sdc_pkg::TWR_CYC : 10'(cl);      // RQ8
                d.st  = sdc_pkg::S_WAIT;
                d.nxt = sdc_pkg::S_PRE;
            end
            sdc_pkg::S_PRE: begin
                d.pin.cmd  = sdc_pkg::CMD_PRE;
                d.pin.addr = 11'h000;
                d.open = 1'b0;
                d.cnt  = sdc_pkg::TRP_CYC;
                d.st   = sdc_pkg::S_WAIT;
                d.nxt  = sdc_pkg::S_IDLE;
            end
            sdc_pkg::S_WAIT: begin
                if (q.cnt == 10'h000) begin                     // RQ28
                    d.st = q.nxt;
                end
            end
            default: d.st = sdc_pkg::S_PWR;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q             <= '0;
            q.cnt         <= sdc_pkg::INIT_CYC;
            q.refcnt      <= sdc_pkg::REFI_CYC;
            q.mode        <= sdc_pkg::MODE_RST;
            q.pin.cke     <= 1'b1;
            q.pin.cmd     <= sdc_pkg::CMD_NOP;
            q.pin.dqm     <= 4'hf;
        end else begin
            q <= d;
        end
    end

    // ========================================
    // Checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_rd;
        q.pin.cmd == sdc_pkg::CMD_RD;
    endsequence
    sequence s_wr;
        q.pin.cmd == sdc_pkg::CMD_WR;
    endsequence

    pwr_quiet_a: assert property (q.st == sdc_pkg::S_PWR |-> // RQ14
        q.pin.cmd == sdc_pkg::CMD_NOP)
        else $error("command during power-up wait");
    init_order_a: assert property (q.pin.cmd == sdc_pkg::CMD_LMR && // RQ15
        !$past(q.init_done) |-> q.refs == 2'h2)
        else $error("mode loaded before two refreshes");
    mode_first_a: assert property (q.pin.cmd == sdc_pkg::CMD_ACT |-> // RQ16
        q.init_done)
        else $error("activate before mode load");
    row_open_a: assert property ((s_rd or s_wr) |-> // RQ13
        q.open && $past(q.st) == sdc_pkg::S_RW)
        else $error("access without open row");
    lmr_idle_a: assert property (q.pin.cmd == sdc_pkg::CMD_LMR |-> // RQ19
        !q.open && q.pin.addr[8:7] == 2'h0)
        else $error("mode load with open bank or test mode");
    mask_write_a: assert property (s_wr |-> // RQ7
        $past(q.pin.dqm) == 4'hf && $past(q.pin.dqm, 2) == 4'hf)
        else $error("data mask not raised before write");
    rd_lat2_a: assert property (s_rd ##0 (cl == 3'h2) |-> // RQ23
        (!q.rd_stb) [*3] ##1 q.rd_stb)
        else $error("read capture not at latency two");
    rd_lat3_a: assert property (s_rd ##0 (cl == 3'h3) |-> // RQ23
        ##4 q.rd_stb)
        else $error("read capture not at latency three");
    act_bank_a: assert property (q.pin.cmd == sdc_pkg::CMD_ACT |-> // RQ12
        q.pin.ba == $past(q.acc[ACC_W_M1 -: 2]))
        else $error("activate bank mismatch");
    page_term_a: assert property ((s_rd or s_wr) ##0 page |=> // RQ21
        q.pin.cmd == sdc_pkg::CMD_TERM)
        else $error("page burst not terminated");
endmodule // sdc_host

// file: bench/sdc_mem_model.sv
// Behavioural model of the four-bank memory device
`timescale 1ns/1ns
module sdc_mem_model (
    // Clock and reset
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // Device pins
    input  wire sdc_pkg::sdc_pin_s mem,
    output logic [31:0]            dq,
    // Observation
    output logic [12:0]            mode_q,
    output logic [7:0]             viol_q
);
    // ========================================
    // Storage and bank state
    logic [31:0] ary [logic [20:0]];
    logic [10:0] row_q [4];
    logic [3:0]  open_q;
    logic [2:0]  seq_q;
    logic [1:0]  rcnt_q;
    logic [7:0]  dqm_q;
    logic [31:0] rval_q;
    int          cyc_q;
    int          wgap_q;
    // ========================================
    // Command decode
    always @(posedge aclk) begin : dec
        logic [20:0] key;
        int          v;
        logic        cl3;
        key = {mem.ba, row_q[mem.ba], mem.addr[7:0]};
        v = 0;
        cl3 = mode_q[6:4] == sdc_pkg::CL_3;
        if (!aresetn) begin
            cyc_q <= 0;
            seq_q <= 3'h0;
            open_q <= 4'h0;
            viol_q <= 8'h0;
            rcnt_q <= 2'h0;
            wgap_q <= 99;
        end else begin
            cyc_q <= cyc_q + 1;
            wgap_q <= wgap_q + 1;
            dqm_q <= {dqm_q[3:0], mem.dqm};
            if (rcnt_q != 2'h0) rcnt_q <= rcnt_q - 2'h1;
            if (mem.cmd != sdc_pkg::CMD_NOP && cyc_q < 999) v++;
            case (mem.cmd)
            sdc_pkg::CMD_PRE: begin
                if (seq_q == 3'h0) seq_q <= 3'h1;
                // Write recovery before a closing precharge
                if (wgap_q < int'(sdc_pkg::TWR_CYC)) v++;
                open_q <= mem.addr[10] ? 4'h0 : open_q & ~(4'h1 << mem.ba);
            end
            sdc_pkg::CMD_REF: begin
                if (seq_q == 3'h1 || seq_q == 3'h2) seq_q <= seq_q + 3'h1;
                else if (seq_q != 3'h4) v++;
                if (open_q != 4'h0) v++;
            end
            sdc_pkg::CMD_LMR: begin
                if (seq_q < 3'h3 || open_q != 4'h0) v++;
                if (mem.addr[8:7] != 2'h0) v++;
                seq_q <= 3'h4;
                mode_q <= {2'h0, mem.addr};
            end
            sdc_pkg::CMD_ACT: begin
                if (seq_q != 3'h4) v++;
                row_q[mem.ba] <= mem.addr;
                open_q[mem.ba] <= 1'b1;
            end
            sdc_pkg::CMD_RD, sdc_pkg::CMD_WR: begin
                if (seq_q != 3'h4 || !open_q[mem.ba]) v++;
                if (mem.addr[10]) open_q[mem.ba] <= 1'b0;
                if (!ary.exists(key)) ary[key] = 32'h0;
                if (mem.cmd == sdc_pkg::CMD_RD) begin
                    rval_q <= ary[key];
                    rcnt_q <= cl3 ? 2'h3 : 2'h2;
                end else begin
                    wgap_q <= 0;
                    if (dqm_q != 8'hff || !mem.dq_oe) v++;
                    for (int b = 0; b < 4; b++)
                        if (!mem.dqm[b]) ary[key][8*b +: 8] = mem.dq_o[8*b +: 8];
                end
            end
            default: ;
            endcase
            viol_q <= viol_q + 8'(v);
        end
    end : dec
    // Data one cycle before the latency edge, scrambled otherwise
    initial dq = 32'h0;
    always @(posedge aclk)
        dq <= (aresetn && rcnt_q == 2'h2) ? rval_q : ~dq;
endmodule // sdc_mem_model

// file: bench/sdc_host_tb.sv
// Self-checking bench for the SDRAM host controller
`timescale 1ns/1ns
module sdc_host_tb;
    // ========================================
    // Signals
    logic              aclk, aresetn, awvalid, awready, wvalid, wready;
    logic              bvalid, bready, arvalid, arready, rvalid, rready;
    logic [7:0]        awaddr, araddr;
    logic [31:0]       wdata, rdata, dq_i;
    logic [3:0]        wstrb;
    logic [1:0]        bresp, rresp;
    logic [12:0]       mode_q;
    logic [7:0]        viol_q;
    sdc_pkg::sdc_pin_s mem;
    int                err_total, tests_run;
    sdc_host u_dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
        .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
        .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .mem, .dq_i);
    sdc_mem_model u_mem (.aclk, .aresetn, .mem, .dq(dq_i), .mode_q,
        .viol_q);
    initial aclk = 1'b0;
    always #50 aclk = ~aclk;
    // ========================================
    // Shared tasks
    task automatic chk(input string nm, input logic [31:0] e, g);
        tests_run++;
        if (g !== e) begin
            err_total++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                          output logic [1:0] r);
        logic pa, pw, ha, hw;
        pa = 1'b1;
        pw = 1'b1;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (pa || pw) begin
            @(negedge aclk);
            ha = pa && awready;
            hw = pw && wready;
            @(posedge aclk);
            if (ha) awvalid <= 1'b0;
            if (hw) wvalid <= 1'b0;
            pa = pa && !ha;
            pw = pw && !hw;
        end
        do begin
            @(negedge aclk);
            r = bresp;
            ha = bvalid;
            @(posedge aclk);
        end while (!ha);
    endtask
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                          output logic [1:0] r);
        logic h;
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(negedge aclk);
            h = arready;
            @(posedge aclk);
        end while (!h);
        arvalid <= 1'b0;
        do begin
            @(negedge aclk);
            d = rdata;
            r = rresp;
            h = rvalid;
            @(posedge aclk);
        end while (!h);
    endtask
    task automatic wait_ready;
        logic [31:0] s;
        logic [1:0]  r;
        do axi_rd(sdc_pkg::REG_STATUS, s, r);
        while (s[2:0] !== 3'h1);
    endtask
    task automatic mem_op(input logic [31:0] a, d, input logic w,
                          output logic [31:0] q);
        logic [1:0] r;
        axi_wr(sdc_pkg::REG_ADDR, a, r);
        axi_wr(sdc_pkg::REG_WDATA, d, r);
        axi_wr(sdc_pkg::REG_CTRL, {30'h0, w, 1'b1}, r);
        wait_ready;
        axi_rd(sdc_pkg::REG_RDATA, q, r);
    endtask
    // ========================================
    // Scenarios
    task automatic t_init;
        logic [31:0] s;
        logic [1:0]  r;
        axi_rd(sdc_pkg::REG_STATUS, s, r);
        chk("status read resp", 32'h0, {30'h0, r});
        chk("early init flag", 32'h0, {31'h0, s[0]});
        wait_ready;
        chk("init mode", 32'(sdc_pkg::MODE_RST), 32'(mode_q));
        chk("init faults", 32'h0, {24'h0, viol_q});
    endtask
    task automatic t_unmapped;
        logic [31:0] d;
        logic [1:0]  r;
        axi_wr(8'h40, 32'hffff_ffff, r);
        chk("unmapped write resp", 32'h2, {30'h0, r});
        axi_rd(8'h40, d, r);
        chk("unmapped read resp", 32'h2, {30'h0, r});
        chk("unmapped read data", 32'h0, d);
    endtask
    task automatic t_geometry;
        logic [31:0] a [4];
        logic [31:0] q;
        a = '{32'h0000_0000, 32'h001f_ffff, 32'h0008_05ff, 32'h0017_ff00};
        foreach (a[i]) mem_op(a[i], 32'hc0de_0000 ^ a[i], 1'b1, q);
        foreach (a[i]) begin
            mem_op(a[i], 32'h0, 1'b0, q);
            chk("geometry word", 32'hc0de_0000 ^ a[i], q);
        end
    endtask
    task automatic t_modes;
        logic [12:0] m [5];
        logic [31:0] a, q, e;
        logic [1:0]  r;
        m = '{13'h003a, 13'h0027, 13'h0233, 13'h19a1, 13'h0020};
        foreach (m[i]) begin
            a = 32'h0010_2345 + 32'(i);
            axi_wr(sdc_pkg::REG_MODE, {19'h0, m[i]}, r);
            chk("mode write resp", 32'h0, {30'h0, r});
            wait_ready;
            e = 32'(m[i] & 13'h067f);
            chk("mode word", e, 32'(mode_q));
            e = 32'h5a5a_0000 + a;
            mem_op(a, e, 1'b1, q);
            mem_op(a, 32'h0, 1'b0, q);
            chk("mode data", e, q);
        end
    endtask
    // ========================================
    // Main sequence and watchdog
    initial begin : main
        aresetn = 1'b0;
        {awvalid, wvalid, arvalid} = 3'h0;
        {bready, rready} = 2'h3;
        wstrb = 4'hf;
        {awaddr, araddr, wdata} = 48'h0;
        err_total = 0;
        tests_run = 0;
        repeat (4) @(posedge aclk);
        @(negedge aclk);
        chk("reset command", 32'h7, {28'h0, mem.cmd});
        chk("reset pins", 32'h1e, {27'h0, mem.dqm, mem.dq_oe});
        chk("reset valids", 32'h0, {30'h0, bvalid, rvalid});
        @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_init;
        t_unmapped;
        t_geometry;
        t_modes;
        chk("device faults", 32'h0, 32'(viol_q));
        close_out;
    end
    initial begin : watchdog
        repeat (40000) @(posedge aclk);
        err_total++;
        close_out;
    end
endmodule // sdc_host_tb
